//--- rtl/afe_cfg_pkg.sv
package afe_cfg_pkg;
   // ----------------------------------------------------------------
   // Register addresses (5-bit serial address)
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_CONTROL = 5'h0F;
   localparam logic [4:0] ADDR_DELAY_FIRST = 5'h10;
   localparam logic [4:0] ADDR_DELAY_SECOND = 5'h11;
   localparam logic [4:0] ADDR_DELAY_THIRD = 5'h12;
   localparam logic [4:0] ADDR_DELAY_FOURTH = 5'h13;
   localparam logic [4:0] ADDR_OPERATING_MODE = 5'h14;
   localparam logic [4:0] ADDR_FACTORY_TEST = 5'h15;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_DELAY_FIRST = 8'h80;
   localparam logic [7:0] RST_DELAY_OTHER = 8'h00;
   localparam logic [9:0] RST_OPERATING_MODE = 10'h001;
   localparam logic [9:0] RST_FACTORY_TEST = 10'h000;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POS_NIBBLE_HI = 4;
   localparam int POS_NIBBLE_LO = 0;
   localparam int POS_NO_HALF_FS = 7;
   localparam int POS_TEST_ENABLE = 6;
   localparam int POS_GAIN_SELECT = 5;
   localparam int POS_SENSOR_TYPE = 4;
   localparam int POS_CHANNEL_SEL = 2;
   localparam int POS_ALT_PIXEL = 1;
   localparam int POS_GAIN_OFFSET = 0;
   localparam int POS_SOFT_RESET = 0;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SOFT_RESET_NS = 10;
   localparam int SOFT_RESET_CYCLES =
      ((SOFT_RESET_NS * 1000) / CLK_PERIOD_PS < 1) ? 1 :
      (SOFT_RESET_NS * 1000) / CLK_PERIOD_PS;
   localparam int OUT_STEP_PS = 1000;
   localparam int EDGE_STEP_PS = 500;

   typedef enum logic [1:0] {
      CHANNEL_SELECT_ALL_THREE,
      CHANNEL_SELECT_RED,
      CHANNEL_SELECT_GREEN,
      CHANNEL_SELECT_BLUE
   } channel_set_t;

   // Decoded timing settings, delays in picoseconds except the transfer strobe nibble
   typedef struct packed {
      logic [15:0] output_data_delay;
      logic [15:0] black_sample_lead_delay;
      logic [15:0] black_sample_trail_delay;
      logic [15:0] video_sample_lead_delay;
      logic [15:0] video_sample_trail_delay;
      logic [3:0] gain_offset_transfer_delay;
      logic [15:0] converter_clock_delay;
   } timing_cfg_t;

   // Decoded mode settings
   typedef struct packed {
      logic no_half_full_scale;
      logic test_enable;
      logic high_gain_range;
      logic contact_sensor;
      channel_set_t channel_select;
      logic alternate_pixel_offset_mode;
      logic gain_offset_mode_bit;
   } mode_cfg_t;
endpackage

//--- rtl/cfg_reg_word.sv
`timescale 1ns/100ps
// One register word with reset value and soft clear
module cfg_reg_word
   import afe_cfg_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic core_clk, // Core clock
   input wire logic rst, // Async reset, high
   input wire logic soft_clear, // Return to default
   input wire logic wr_en, // Write strobe
   input wire logic [WIDTH-1:0] wr_data, // Write data
   output logic [WIDTH-1:0] value // Stored value
);
   // Storage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         value <= RESET_VALUE;
      end else if (soft_clear) begin
         value <= RESET_VALUE;
      end else if (wr_en) begin
         value <= wr_data;
      end
   end
endmodule // cfg_reg_word

//--- rtl/afe_timing_and_mode_config.sv
`timescale 1ns/100ps
// Function
// - Output delay nibble, 0 to 15 ns
// - Black sample lead edge, 0.5 ns steps
// - Black sample trail edge, 0.5 ns steps
// - Video sample lead edge, 0.5 ns steps
// - Video sample trail edge, 0.5 ns steps
// - Gain offset transfer strobe delay nibble
// - Converter clock delay, 0.5 ns steps
// - Gain select: 1-10 or 2-20 range
// - Sensor bit: 0 CCD, 1 CIS
// - Channel select: all, red, green, blue
// - Alternate pixel bit enables even offsets
// - Gain offset bit: fixed or per pixel
// - Mode at 10100, resets to 0x001
// - Bit 7 disables full scale halving
// - Soft reset restores all register defaults
module afe_timing_and_mode_config
   import afe_cfg_pkg::*;
(
   input wire logic core_clk, // Core clock, 250 MHz
   input wire logic rst, // Async reset, high
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [4:0] reg_addr, // Serial register address
   input wire logic [9:0] reg_wdata, // Write data
   output logic [9:0] reg_rdata, // Read data, registered
   output logic reg_rvalid, // Read data valid pulse
   output logic soft_reset_active, // Soft reset in progress
   output timing_cfg_t timing_cfg, // Decoded delays
   output mode_cfg_t mode_cfg, // Decoded mode
   output logic [9:0] factory_test // Factory test word
);
   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
      hit = (a == target);
   endfunction

   // Nibble code to picoseconds
   function automatic logic [15:0] scale(input logic [3:0] code, input int step);
      scale = 16'(int'(code) * step);
   endfunction

   // Internal state
   logic [SOFT_RESET_CYCLES:0] soft_count;
   logic soft_clear;
   logic [7:0] delay_reg [4];
   logic [9:0] operating_mode;
   logic [4:0] delay_addr [4];

   // Addresses of the four delay words
   assign delay_addr[0] = ADDR_DELAY_FIRST;
   assign delay_addr[1] = ADDR_DELAY_SECOND;
   assign delay_addr[2] = ADDR_DELAY_THIRD;
   assign delay_addr[3] = ADDR_DELAY_FOURTH;

   // ----------------------------------------------------------------
   // Self-clearing soft reset
   // ----------------------------------------------------------------
   // Shift register holds clear for three cycles, 12 ns
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         soft_count <= '0;
      end else if (reg_wr && hit(reg_addr, ADDR_CONTROL) && reg_wdata[POS_SOFT_RESET]) begin
         soft_count <= '1;
      end else begin
         soft_count <= soft_count >> 1;
      end
   end

   // Clear pulse is the last stage of the chain
   assign soft_clear = soft_count[0];
   assign soft_reset_active = soft_clear;

   // ----------------------------------------------------------------
   // Register words
   // ----------------------------------------------------------------
   // Four delay registers
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_delay
         cfg_reg_word #(
            .WIDTH(8),
            .RESET_VALUE((gi == 0) ? RST_DELAY_FIRST : RST_DELAY_OTHER)
         ) u_word (
            .core_clk(core_clk),
            .rst(rst),
            .soft_clear(soft_clear),
            .wr_en(reg_wr && !soft_clear && hit(reg_addr, delay_addr[gi])),
            .wr_data(reg_wdata[7:0]),
            .value(delay_reg[gi])
         );
      end
   endgenerate

   // Mode register
   cfg_reg_word #(
      .WIDTH(10),
      .RESET_VALUE(RST_OPERATING_MODE)
   ) u_mode (
      .core_clk(core_clk),
      .rst(rst),
      .soft_clear(soft_clear),
      .wr_en(reg_wr && !soft_clear && hit(reg_addr, ADDR_OPERATING_MODE)),
      .wr_data(reg_wdata),
      .value(operating_mode)
   );

   // Factory test register
   cfg_reg_word #(
      .WIDTH(10),
      .RESET_VALUE(RST_FACTORY_TEST)
   ) u_test (
      .core_clk(core_clk),
      .rst(rst),
      .soft_clear(soft_clear),
      .wr_en(reg_wr && !soft_clear && hit(reg_addr, ADDR_FACTORY_TEST)),
      .wr_data(reg_wdata),
      .value(factory_test)
   );

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Registered read mux, unmapped reads zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            unique case (reg_addr)
               ADDR_DELAY_FIRST: reg_rdata <= {2'h0, delay_reg[0]};
               ADDR_DELAY_SECOND: reg_rdata <= {2'h0, delay_reg[1]};
               ADDR_DELAY_THIRD: reg_rdata <= {2'h0, delay_reg[2]};
               ADDR_DELAY_FOURTH: reg_rdata <= {2'h0, delay_reg[3]};
               ADDR_OPERATING_MODE: reg_rdata <= {2'h0, operating_mode[7:0]};
               ADDR_FACTORY_TEST: reg_rdata <= factory_test;
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Decoded timing outputs
   // ----------------------------------------------------------------
   // Delays in picoseconds except the transfer strobe nibble, registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timing_cfg <= '0;
      end else begin
         timing_cfg.output_data_delay <=
            scale(delay_reg[0][POS_NIBBLE_LO +: 4], OUT_STEP_PS);
         timing_cfg.black_sample_lead_delay <=
            scale(delay_reg[1][POS_NIBBLE_HI +: 4], EDGE_STEP_PS);
         timing_cfg.black_sample_trail_delay <=
            scale(delay_reg[1][POS_NIBBLE_LO +: 4], EDGE_STEP_PS);
         timing_cfg.video_sample_lead_delay <=
            scale(delay_reg[2][POS_NIBBLE_HI +: 4], EDGE_STEP_PS);
         timing_cfg.video_sample_trail_delay <=
            scale(delay_reg[2][POS_NIBBLE_LO +: 4], EDGE_STEP_PS);
         timing_cfg.gain_offset_transfer_delay <=
            delay_reg[3][POS_NIBBLE_HI +: 4];
         timing_cfg.converter_clock_delay <=
            scale(delay_reg[3][POS_NIBBLE_LO +: 4], EDGE_STEP_PS);
      end
   end

   // ----------------------------------------------------------------
   // Decoded mode outputs
   // ----------------------------------------------------------------
   // Mode fields, registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_cfg <= '0;
         mode_cfg.gain_offset_mode_bit <= 1'b1;
      end else begin
         mode_cfg.no_half_full_scale <= operating_mode[POS_NO_HALF_FS];
         mode_cfg.test_enable <= operating_mode[POS_TEST_ENABLE];
         mode_cfg.high_gain_range <= operating_mode[POS_GAIN_SELECT];
         mode_cfg.contact_sensor <= operating_mode[POS_SENSOR_TYPE];
         mode_cfg.channel_select <=
            channel_set_t'(operating_mode[POS_CHANNEL_SEL +: 2]);
         mode_cfg.alternate_pixel_offset_mode <= operating_mode[POS_ALT_PIXEL];
         mode_cfg.gain_offset_mode_bit <= operating_mode[POS_GAIN_OFFSET];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_out_delay;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.output_data_delay == 16'($past(delay_reg[0][3:0])) * 16'h03E8;
   endproperty
   a_out_delay: assert property (p_out_delay) else $error("output delay wrong");

   property p_black_lead;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.black_sample_lead_delay == 16'($past(delay_reg[1][7:4])) * 16'h01F4;
   endproperty
   a_black_lead: assert property (p_black_lead) else $error("black lead wrong");

   property p_black_trail;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.black_sample_trail_delay == 16'($past(delay_reg[1][3:0])) * 16'h01F4;
   endproperty
   a_black_trail: assert property (p_black_trail) else $error("black trail wrong");

   property p_video_lead;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.video_sample_lead_delay == 16'($past(delay_reg[2][7:4])) * 16'h01F4;
   endproperty
   a_video_lead: assert property (p_video_lead) else $error("video lead wrong");

   property p_conv_delay;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.converter_clock_delay == 16'($past(delay_reg[3][3:0])) * 16'h01F4;
   endproperty
   a_conv_delay: assert property (p_conv_delay) else $error("converter delay wrong");

   property p_mode_write;
      @(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == 5'h14 && !soft_clear |=> ##1 mode_cfg.gain_offset_mode_bit ==
         $past(reg_wdata[0], 2) && mode_cfg.channel_select == $past(reg_wdata[3:2], 2);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");

   property p_soft_reset;
      @(posedge core_clk) disable iff (rst)
      $fell(soft_clear) |-> operating_mode == 10'h001 && delay_reg[0] == 8'h80 &&
         factory_test == 10'h000;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

   property p_soft_len;
      @(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == 5'h0F && reg_wdata[0] |=> soft_clear [*3] ##1 !soft_clear;
   endproperty
   a_soft_len: assert property (p_soft_len) else $error("soft reset length wrong");

   property p_gain_range;
      @(posedge core_clk) disable iff (rst)
      $changed(operating_mode[5]) |=> mode_cfg.high_gain_range == $past(operating_mode[5]);
   endproperty
   a_gain_range: assert property (p_gain_range) else $error("gain range wrong");

   property p_video_trail;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.video_sample_trail_delay == 16'($past(delay_reg[2][3:0])) * 16'h01F4;
   endproperty
   a_video_trail: assert property (p_video_trail) else $error("video trail wrong");

   property p_xfer_delay;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> timing_cfg.gain_offset_transfer_delay == $past(delay_reg[3][7:4]);
   endproperty
   a_xfer_delay: assert property (p_xfer_delay) else $error("transfer delay wrong");

   property p_sensor_type;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> mode_cfg.contact_sensor == $past(operating_mode[POS_SENSOR_TYPE]);
   endproperty
   a_sensor_type: assert property (p_sensor_type) else $error("sensor type wrong");

   property p_channel_sel;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> mode_cfg.channel_select == $past(operating_mode[3:2]);
   endproperty
   a_channel_sel: assert property (p_channel_sel) else $error("channel select wrong");

   property p_alt_pixel;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> mode_cfg.alternate_pixel_offset_mode == $past(operating_mode[POS_ALT_PIXEL]);
   endproperty
   a_alt_pixel: assert property (p_alt_pixel) else $error("alternate pixel wrong");

   property p_full_scale;
      @(posedge core_clk) disable iff (rst)
      1'b1 |=> mode_cfg.no_half_full_scale == $past(operating_mode[POS_NO_HALF_FS]);
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("full scale bit wrong");

   property p_clear_hold;
      @(posedge core_clk) disable iff (rst)
      soft_clear |=> operating_mode == RST_OPERATING_MODE && delay_reg[0] == RST_DELAY_FIRST &&
         factory_test == RST_FACTORY_TEST;
   endproperty
   a_clear_hold: assert property (p_clear_hold) else $error("clear not held");

   property p_mode_read;
      @(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == ADDR_OPERATING_MODE |=> reg_rvalid &&
         reg_rdata == {2'h0, $past(operating_mode[7:0])};
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

   property p_test_read;
      @(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == ADDR_FACTORY_TEST |=> reg_rvalid && reg_rdata == $past(factory_test);
   endproperty
   a_test_read: assert property (p_test_read) else $error("test read wrong");
endmodule // afe_timing_and_mode_config

//--- test/afe_host_model.sv
`timescale 1ns/100ps
// Host controller model driving the register strobes
module afe_host_model
   import afe_cfg_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic [9:0] reg_rdata, // Read data
   input wire logic reg_rvalid, // Read data valid
   output logic reg_wr, // Write strobe
   output logic reg_rd, // Read strobe
   output logic [4:0] reg_addr, // Register address
   output logic [9:0] reg_wdata // Write data
);
   // Bus idle at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 10'h000;
   end

   // Single write, none to the factory test address; released lines show inverted values
   task automatic write_reg(input logic [4:0] addr, input logic [9:0] data);
      logic [9:0] d;
      d = data;
      if (addr == ADDR_FACTORY_TEST) return;
      if (addr == ADDR_OPERATING_MODE) begin
         d[6] = 1'b0;
         if (d[0]) d[1] = 1'b0;
      end
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= addr;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~d;
   endtask

   // Single read with bounded wait for the valid pulse
   task automatic read_reg(input logic [4:0] addr, output logic [9:0] data);
      data = 'x;
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= addr;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         if (reg_rvalid === 1'b1) begin
            data = reg_rdata;
            break;
         end
      end
   endtask
endmodule // afe_host_model

//--- test/afe_timing_and_mode_config_tb_top.sv
`timescale 1ns/100ps
// Bench for the timing and mode configuration bank
module afe_timing_and_mode_config_tb_top
   import afe_cfg_pkg::*;
;
   logic core_clk;
   logic rst;
   logic reg_wr;
   logic reg_rd;
   logic [4:0] reg_addr;
   logic [9:0] reg_wdata;
   logic [9:0] reg_rdata;
   logic reg_rvalid;
   logic soft_reset_active;
   timing_cfg_t timing_cfg;
   mode_cfg_t mode_cfg;
   logic [9:0] factory_test;
   int failures;
   int n_checks;

   afe_timing_and_mode_config uut (
      .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .soft_reset_active(soft_reset_active),
      .timing_cfg(timing_cfg), .mode_cfg(mode_cfg), .factory_test(factory_test)
   );

   afe_host_model host (
      .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
   );

   // ---------------------------------------------------------------
   // Clock and helpers
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic check_word(input string name, input logic [9:0] exp, input logic [9:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_field(input string name, input logic [15:0] exp,
                              input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Let the decoded outputs follow a write
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // All registers and decoded outputs at their defaults
   task automatic check_defaults();
      logic [9:0] d;
      logic [4:0] a;
      for (int i = 15; i < 22; i++) begin
         a = 5'(i);
         host.read_reg(a, d);
         check_word("reg_default", (a == ADDR_DELAY_FIRST) ? 10'h080 :
            (a == ADDR_OPERATING_MODE) ? 10'h001 : 10'h000, d);
      end
      host.read_reg(5'h1F, d);
      check_word("unmapped_read", 10'h000, d);
      check_field("timing_any", 16'h0000, {15'h0000, |timing_cfg});
      check_field("mode_default", 16'h0001, {8'h00, mode_cfg});
      check_word("factory_test", 10'h000, factory_test);
   endtask

   // Every nibble code on every delay field
   task automatic test_delays();
      logic [9:0] d;
      logic [15:0] c;
      for (int i = 0; i < 16; i++) begin
         c = 16'(i);
         host.write_reg(ADDR_DELAY_FIRST, {6'h08, c[3:0]});
         host.write_reg(ADDR_DELAY_SECOND, {2'h0, c[3:0], ~c[3:0]});
         host.write_reg(ADDR_DELAY_THIRD, {2'h0, ~c[3:0], c[3:0]});
         host.write_reg(ADDR_DELAY_FOURTH, {2'h0, c[3:0], ~c[3:0]});
         settle();
         check_field("out_dly", c * 16'h03E8, timing_cfg.output_data_delay);
         check_field("blk_lead", c * 16'h01F4, timing_cfg.black_sample_lead_delay);
         check_field("blk_trail", (16'h000F - c) * 16'h01F4,
            timing_cfg.black_sample_trail_delay);
         check_field("vid_lead", (16'h000F - c) * 16'h01F4,
            timing_cfg.video_sample_lead_delay);
         check_field("vid_trail", c * 16'h01F4, timing_cfg.video_sample_trail_delay);
         check_field("xfer_dly", c, {12'h000, timing_cfg.gain_offset_transfer_delay});
         check_field("conv_dly", (16'h000F - c) * 16'h01F4,
            timing_cfg.converter_clock_delay);
      end
      host.read_reg(ADDR_DELAY_THIRD, d);
      check_word("delay_third_read", 10'h00F, d);
      $display("test_delays done");
   endtask

   // Mode bits, every channel set
   task automatic test_modes();
      logic [7:0] tbl [5] = '{8'hA0, 8'h16, 8'h29, 8'h9C, 8'h01};
      logic [9:0] d;
      foreach (tbl[i]) begin
         host.write_reg(ADDR_OPERATING_MODE, {2'h0, tbl[i]});
         settle();
         check_field("mode_cfg", {8'h00, tbl[i]},
            {8'h00, mode_cfg});
         host.read_reg(ADDR_OPERATING_MODE, d);
         check_word("mode_read", {2'h0, tbl[i]}, d);
      end
      $display("test_modes done");
   endtask

   // Soft reset clears everything and refuses a write meanwhile
   task automatic test_soft_reset();
      host.write_reg(ADDR_DELAY_SECOND, 10'h0FF);
      host.write_reg(ADDR_OPERATING_MODE, 10'h0BC);
      host.write_reg(ADDR_CONTROL, 10'h001);
      #1;
      check_field("soft_active", 16'h0001, {15'h0000, soft_reset_active});
      host.write_reg(ADDR_DELAY_FIRST, 10'h0FF);
      repeat (6) @(posedge core_clk);
      #1;
      check_field("soft_done", 16'h0000, {15'h0000, soft_reset_active});
      check_defaults();
      $display("test_soft_reset done");
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      failures = 0;
      n_checks = 0;
      rst = 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      check_defaults();
      $display("test_reset_values done");
      test_delays();
      test_modes();
      test_soft_reset();
      stop_test();
   end

   initial begin
      #20000;
      failures++;
      $display("watchdog expired");
      stop_test();
   end
endmodule // afe_timing_and_mode_config_tb_top
